// file: tmr8_defs.svh
// register offsets, field positions, codes and reset values of the timer
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// register byte offsets on the apb bus
`define TMR8_OFF_CTRL  8'h00
`define TMR8_OFF_CMPA  8'h04
`define TMR8_OFF_CMPB  8'h08
`define TMR8_OFF_COUNT 8'h0c
`define TMR8_OFF_STAT  8'h10
`define TMR8_OFF_MASK  8'h14
`define TMR8_OFF_PORT  8'h18

// control register fields
`define TMR8_WGM_HI  2
`define TMR8_WGM_LO  0
`define TMR8_CS_HI   5
`define TMR8_CS_LO   3
`define TMR8_COMA_HI 7
`define TMR8_COMA_LO 6
`define TMR8_COMB_HI 9
`define TMR8_COMB_LO 8

// port register fields: direction, then port data
`define TMR8_DIR_HI 1
`define TMR8_DIR_LO 0
`define TMR8_DAT_HI 3
`define TMR8_DAT_LO 2

// status and mask bits
`define TMR8_ST_OVF  0
`define TMR8_ST_CMPA 1
`define TMR8_ST_CMPB 2
`define TMR8_ST_HI   2

// waveform mode select codes
`define TMR8_WGM_NORMAL  3'h0
`define TMR8_WGM_CLEAR   3'h2
`define TMR8_WGM_PWM_MAX 3'h3
`define TMR8_WGM_PWM_CMP 3'h7

// compare output mode codes
`define TMR8_COM_OFF    2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR  2'h2
`define TMR8_COM_SET    2'h3

// counter limits
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX    8'hff

// prescale select codes
`define TMR8_CS_STOP    3'h0
`define TMR8_CS_DIV1    3'h1
`define TMR8_CS_DIV8    3'h2
`define TMR8_CS_DIV32   3'h3
`define TMR8_CS_DIV64   3'h4
`define TMR8_CS_DIV128  3'h5
`define TMR8_CS_DIV256  3'h6
`define TMR8_CS_DIV1024 3'h7

// prescale masks, factor minus one
`define TMR8_M_DIV1    10'h000
`define TMR8_M_DIV8    10'h007
`define TMR8_M_DIV32   10'h01f
`define TMR8_M_DIV64   10'h03f
`define TMR8_M_DIV128  10'h07f
`define TMR8_M_DIV256  10'h0ff
`define TMR8_M_DIV1024 10'h3ff

// reset values
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_WORD 32'h0000_0000

`endif

// file: tmr8_pkg.sv
// types shared by the timer modules
`default_nettype none

package tmr8_pkg;

  // decoded counting mode, one-hot
  typedef enum logic [2:0] {
    tmr8_mode_normal = 3'b001,
    tmr8_mode_clear  = 3'b010,
    tmr8_mode_pwm    = 3'b100
  } tmr8_mode_type;

  // compare output mode field
  typedef logic [1:0] tmr8_com_type;

endpackage

`default_nettype wire

// file: tmr8_wave_if.sv
// channel events from the counter to a waveform unit
`timescale 1ns/1ps
`default_nettype none

interface tmr8_wave_if;
  logic                   pwm;     // single-slope mode active
  logic                   tog_ok;  // toggle allowed in pwm
  tmr8_pkg::tmr8_com_type com;     // compare output mode
  logic                   hit;     // timer tick on compare match
  logic                   bottom;  // timer tick restarting at bottom
  logic                   wave;    // waveform level

  modport ctrl (output pwm, tog_ok, com, hit, bottom, input wave);
  modport unit (input pwm, tog_ok, com, hit, bottom, output wave);
endinterface

`default_nettype wire

// file: tmr8_prescale.sv
// prescaler producing one-cycle timer ticks from the i/o clock
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_prescale (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // clock select and tick
  input  wire logic [2:0] sel,
  output logic            tick
);
  import tmr8_pkg::*;

  logic [9:0] div_q;

  // mask of the low divider bits for a select code
  function automatic logic [9:0] div_mask(input logic [2:0] s);
    case (s)
      `TMR8_CS_DIV8:    div_mask = `TMR8_M_DIV8;
      `TMR8_CS_DIV32:   div_mask = `TMR8_M_DIV32;
      `TMR8_CS_DIV64:   div_mask = `TMR8_M_DIV64;
      `TMR8_CS_DIV128:  div_mask = `TMR8_M_DIV128;
      `TMR8_CS_DIV256:  div_mask = `TMR8_M_DIV256;
      `TMR8_CS_DIV1024: div_mask = `TMR8_M_DIV1024;
      default:          div_mask = `TMR8_M_DIV1;
    endcase
  endfunction

  // free-running divider shared by all factors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  // tick once every factor cycles, never when stopped
  assign tick = (sel != `TMR8_CS_STOP) &&
                ((div_q & div_mask(sel)) == div_mask(sel));

endmodule

`default_nettype wire

// file: tmr8_wave.sv
// waveform output unit for one compare channel
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_wave (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // channel events and waveform
  tmr8_wave_if.unit  ch
);
  import tmr8_pkg::*;

  // pwm: bottom takes priority so a compare at top keeps the bottom level (set non-inverting, clear inverting)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch.wave <= 1'b0;
    end else if (ch.pwm) begin
      if (ch.bottom && ch.com == `TMR8_COM_CLEAR) begin
        ch.wave <= 1'b1;
      end else if (ch.bottom && ch.com == `TMR8_COM_SET) begin
        ch.wave <= 1'b0;
      end else if (ch.hit && ch.com == `TMR8_COM_CLEAR) begin
        ch.wave <= 1'b0;
      end else if (ch.hit && ch.com == `TMR8_COM_SET) begin
        ch.wave <= 1'b1;
      end else if (ch.hit && ch.com == `TMR8_COM_TOGGLE && ch.tog_ok) begin
        ch.wave <= ~ch.wave;
      end
    end else if (ch.hit) begin
      if (ch.com == `TMR8_COM_TOGGLE) begin
        ch.wave <= ~ch.wave;
      end else if (ch.com == `TMR8_COM_CLEAR) begin
        ch.wave <= 1'b0;
      end else if (ch.com == `TMR8_COM_SET) begin
        ch.wave <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: tmr8_top.sv
// 8-bit timer with clear-on-match and fast pwm modes, apb registers
//
// Behaviour
// - clear-on-match sets the channel a flag at top; it may interrupt.
// - in clear-on-match a compare write takes effect at once.
// - a compare below the count is missed until the count wraps.
// - output mode 1 in clear-on-match toggles waveform a per match.
// - a waveform reaches its pin only while the pin is an output.
// - toggle frequency is clk / (2 * prescale * (1 + compare)).
// - the prescaler divides by 1, 8, 32, 64, 128, 256 or 1024.
// - clear-on-match sets overflow in the tick passing max to 0x00.
// - mode field values 3 and 7 select fast pwm.
// - fast pwm counts up from bottom to top, then restarts at bottom.
// - fast pwm top is 0xff in mode 3 and the a compare in mode 7.
// - non-inverting pwm clears on compare match and sets at bottom.
// - inverting pwm sets on compare match and clears at bottom.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // port pins
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe
);
  import tmr8_pkg::*;

  localparam int NCH = 2;

  // configuration registers
  logic [2:0]   wgm_q;
  logic [2:0]   cs_q;
  tmr8_com_type com_q [NCH];
  logic [7:0]   cmp_q [NCH];
  logic [7:0]   cmp_act_q [NCH];
  logic [1:0]   dir_q;
  logic [1:0]   dat_q;
  logic [`TMR8_ST_HI:0] mask_q;

  // counter and status
  logic [7:0]   count_q;
  logic [7:0]   count_d;
  logic [`TMR8_ST_HI:0] stat_q;
  logic [`TMR8_ST_HI:0] stat_d;
  logic [`TMR8_ST_HI:0] stat_set;
  logic [`TMR8_ST_HI:0] stat_clr;

  // bus registers
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         irq_q;
  logic [1:0]   pin_out_q;
  logic [1:0]   pin_oe_q;

  // internal nets
  logic          tick;
  logic          done;
  logic          wr_done;
  logic          rd_stat;
  logic [31:0]   rdata;
  tmr8_mode_type mode;
  logic          pwm;
  logic [7:0]    top;
  logic          at_top;
  logic          ovf_hit;
  logic [7:0]    cmp_eff [NCH];
  logic [NCH-1:0] hit;
  logic [NCH-1:0] wave;

  // decode the mode select field into a counting mode
  function automatic tmr8_mode_type mode_of(input logic [2:0] w);
    case (w)
      `TMR8_WGM_CLEAR:   mode_of = tmr8_mode_clear;
      `TMR8_WGM_PWM_MAX: mode_of = tmr8_mode_pwm;
      `TMR8_WGM_PWM_CMP: mode_of = tmr8_mode_pwm;
      default:           mode_of = tmr8_mode_normal;
    endcase
  endfunction

  // true for a mapped register offset
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `TMR8_OFF_CTRL, `TMR8_OFF_CMPA, `TMR8_OFF_CMPB,
      `TMR8_OFF_COUNT, `TMR8_OFF_STAT, `TMR8_OFF_MASK,
      `TMR8_OFF_PORT: addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  endfunction

  // prescaler for the timer clock
  // the divider runs freely, so the first tick after a select may be early
  tmr8_prescale u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (cs_q),
    .tick    (tick)
  );

  // apb handshake: access completes on the edge where pready is high
  assign done    = psel & penable & pready_q;
  assign wr_done = done & pwrite & addr_ok(paddr);
  assign rd_stat = done & ~pwrite & (paddr == `TMR8_OFF_STAT);

  // read data mux
  always_comb begin
    rdata = `TMR8_RST_WORD;
    unique case (paddr)
      `TMR8_OFF_CTRL: begin
        rdata[`TMR8_WGM_HI:`TMR8_WGM_LO]   = wgm_q;
        rdata[`TMR8_CS_HI:`TMR8_CS_LO]     = cs_q;
        rdata[`TMR8_COMA_HI:`TMR8_COMA_LO] = com_q[0];
        rdata[`TMR8_COMB_HI:`TMR8_COMB_LO] = com_q[1];
      end
      `TMR8_OFF_CMPA:  rdata[7:0] = cmp_q[0];
      `TMR8_OFF_CMPB:  rdata[7:0] = cmp_q[1];
      `TMR8_OFF_COUNT: rdata[7:0] = count_q;
      `TMR8_OFF_STAT:  rdata[`TMR8_ST_HI:0] = stat_q;
      `TMR8_OFF_MASK:  rdata[`TMR8_ST_HI:0] = mask_q;
      `TMR8_OFF_PORT: begin
        rdata[`TMR8_DIR_HI:`TMR8_DIR_LO] = dir_q;
        rdata[`TMR8_DAT_HI:`TMR8_DAT_LO] = dat_q;
      end
      default: rdata = `TMR8_RST_WORD;
    endcase
  end

  // one wait state: pready rises at the end of the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
    end else begin
      pready_q <= 1'b0;
    end
  end

  // answer captured with pready; read data holds until the next access,
  // so the status clear can use exactly the bits that were returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
      prdata_q  <= `TMR8_RST_WORD;
    end else if (psel && penable && !pready_q) begin
      pslverr_q <= ~addr_ok(paddr);
      prdata_q  <= pwrite ? `TMR8_RST_WORD : rdata;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // mode and clock select fields of the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wgm_q <= `TMR8_WGM_NORMAL;
      cs_q  <= `TMR8_CS_STOP;
    end else if (wr_done && paddr == `TMR8_OFF_CTRL) begin
      wgm_q <= pwdata[`TMR8_WGM_HI:`TMR8_WGM_LO];
      cs_q  <= pwdata[`TMR8_CS_HI:`TMR8_CS_LO];
    end
  end

  // compare output mode fields of the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_q[0] <= `TMR8_COM_OFF;
      com_q[1] <= `TMR8_COM_OFF;
    end else if (wr_done && paddr == `TMR8_OFF_CTRL) begin
      com_q[0] <= pwdata[`TMR8_COMA_HI:`TMR8_COMA_LO];
      com_q[1] <= pwdata[`TMR8_COMB_HI:`TMR8_COMB_LO];
    end
  end

  // compare value writes, stored at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q[0] <= `TMR8_RST_BYTE;
      cmp_q[1] <= `TMR8_RST_BYTE;
    end else if (wr_done && paddr == `TMR8_OFF_CMPA) begin
      cmp_q[0] <= pwdata[7:0];
    end else if (wr_done && paddr == `TMR8_OFF_CMPB) begin
      cmp_q[1] <= pwdata[7:0];
    end
  end

  // interrupt mask register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_done && paddr == `TMR8_OFF_MASK) begin
      mask_q <= pwdata[`TMR8_ST_HI:0];
    end
  end

  // port register write: pin direction and port data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 2'h0;
      dat_q <= 2'h0;
    end else if (wr_done && paddr == `TMR8_OFF_PORT) begin
      dir_q <= pwdata[`TMR8_DIR_HI:`TMR8_DIR_LO];
      dat_q <= pwdata[`TMR8_DAT_HI:`TMR8_DAT_LO];
    end
  end

  // mode, top and wrap detection
  assign mode   = mode_of(wgm_q);
  assign pwm    = (mode == tmr8_mode_pwm);
  assign top    = (wgm_q == `TMR8_WGM_CLEAR ||
                   wgm_q == `TMR8_WGM_PWM_CMP) ? cmp_eff[0]
                                               : `TMR8_MAX;
  assign at_top = (count_q == top);

  // overflow: max to zero outside pwm, top to bottom in pwm
  assign ovf_hit = tick & (pwm ? at_top
                               : (count_q == `TMR8_MAX));

  // count: software write wins, else up and restart after top
  // letting the write win allows presetting the count while it runs
  always_comb begin
    count_d = count_q;
    if (wr_done && paddr == `TMR8_OFF_COUNT) begin
      count_d = pwdata[7:0];
    end else if (tick && mode != tmr8_mode_normal && at_top) begin
      count_d = `TMR8_BOTTOM;
    end else if (tick) begin
      count_d = count_q + 8'h01;
    end
  end

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `TMR8_BOTTOM;
    end else begin
      count_q <= count_d;
    end
  end

  // per-channel compare, buffered only in pwm
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      tmr8_wave_if wif ();

      // pwm copies the written value at bottom, else immediate
      // buffering in pwm keeps a mid-period write from cutting a pulse
      assign cmp_eff[gi] = pwm ? cmp_act_q[gi] : cmp_q[gi];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_act_q[gi] <= `TMR8_RST_BYTE;
        end else if (!pwm || (tick && at_top)) begin
          cmp_act_q[gi] <= cmp_q[gi];
        end
      end

      // match on the timer tick where count equals compare
      assign hit[gi]    = tick & (count_q == cmp_eff[gi]);
      assign wif.pwm    = pwm;
      assign wif.tog_ok = (gi == 0) && (wgm_q == `TMR8_WGM_PWM_CMP);
      assign wif.com    = com_q[gi];
      assign wif.hit    = hit[gi];
      assign wif.bottom = tick & at_top & pwm;
      assign wave[gi]   = wif.wave;

      tmr8_wave u_wave (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (wif.ctrl)
      );
    end
  endgenerate

  // status: hardware set wins over read clear
  // only returned bits clear, so an event after the capture is not lost
  always_comb begin
    stat_set = '0;
    stat_set[`TMR8_ST_OVF]  = ovf_hit;
    stat_set[`TMR8_ST_CMPA] = hit[0];
    stat_set[`TMR8_ST_CMPB] = hit[1];
    stat_clr = rd_stat ? prdata_q[`TMR8_ST_HI:0] : '0;
    stat_d   = (stat_q & ~stat_clr) | stat_set;
  end

  // sticky status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // interrupt level from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
    end
  end

  // pin drive: waveform only when direction is output
  // registered so a mode change never glitches the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 2'h0;
      pin_oe_q  <= 2'h0;
    end else begin
      pin_oe_q <= dir_q;
      for (int i = 0; i < NCH; i++) begin
        pin_out_q[i] <= (dir_q[i] && com_q[i] != `TMR8_COM_OFF)
                        ? wave[i] : dat_q[i];
      end
    end
  end

  // outputs straight from flip-flops
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign pin_out = pin_out_q;
  assign pin_oe  = pin_oe_q;

endmodule

`default_nettype wire

// file: tmr8_top_properties.sv
// checker of bus, pin and interrupt behaviour at the timer top ports
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_props (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // interrupt and pins
  input  wire logic        irq,
  input  wire logic [1:0]  pin_out,
  input  wire logic [1:0]  pin_oe
);
  logic       done_w;
  logic       wr_port;
  logic       wr_mask;
  logic [1:0] dat_q;
  logic [1:0] dir_q;
  logic [2:0] mask_q;
  logic [1:0] quiet_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completed writes to port and mask registers
  assign done_w  = psel && penable && pready && pwrite;
  assign wr_port = done_w && paddr == `TMR8_OFF_PORT;
  assign wr_mask = done_w && paddr == `TMR8_OFF_MASK;

  // shadow copies of port and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_q  <= 2'h0;
      dir_q  <= 2'h0;
      mask_q <= 3'h0;
    end else begin
      if (wr_port) begin
        dat_q <= pwdata[3:2];
        dir_q <= pwdata[1:0];
      end
      if (wr_mask) begin
        mask_q <= pwdata[2:0];
      end
    end
  end

  // cycles since the last port write, saturating at three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 2'h0;
    end else begin
      quiet_q <= wr_port ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
    end
  end

  a_ready_in_access: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped_ok: assert property (
      pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_read_upper_zero: assert property (
      pready && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("unused read bits not zero");
  a_oe_follows_dir: assert property (
      wr_port |-> ##2 pin_oe == dir_q)
    else $error("pin enable does not follow direction");
  a_oe_only_write: assert property (
      !$stable(pin_oe) |-> $past(wr_port) || $past(wr_port, 2))
    else $error("pin enable changed without port write");
  a_pin_port_data: assert property (
      quiet_q == 2'h3 |-> (pin_out & ~pin_oe) == (dat_q & ~pin_oe))
    else $error("undriven pin does not show port data");
  a_irq_needs_mask: assert property (
      irq |-> (mask_q | $past(mask_q)) != 3'h0)
    else $error("interrupt with all sources masked");
endmodule

bind tmr8_top tmr8_props u_props (
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .prdata  (prdata),
  .pready  (pready),
  .pslverr (pslverr),
  .irq     (irq),
  .pin_out (pin_out),
  .pin_oe  (pin_oe)
);

`default_nettype wire

// file: tmr8_top_bench.sv
// self-checking bench of the timer top over apb
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_defs.svh"

module tmr8_top_bench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          checks_done;
  int          seed;
  int          d;
  int          top;
  int          hi;
  int          lo;
  int          fac[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0]  ra[5] = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h00};
  logic [31:0] rm[5] = '{32'hff, 32'hff, 32'h7, 32'hf, 32'h3ff};

  tmr8_top dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .pin_out (pin_out),
    .pin_oe  (pin_oe)
  );

  // 200 mhz clock
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // cycles until a pin changes level, bounded
  task automatic edge_wait(input int b, output int cyc);
    logic v;
    v = pin_out[b];
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (pin_out[b] === v && cyc < 20000);
  endtask

  // stop, clear count, load compares, start with a new control word
  task automatic setup(input int ca, input int cb, input logic [31:0] c);
    apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
    apb(1'b1, `TMR8_OFF_COUNT, 32'h0);
    apb(1'b1, `TMR8_OFF_CMPA, 32'(ca));
    apb(1'b1, `TMR8_OFF_CMPB, 32'(cb));
    apb(1'b1, `TMR8_OFF_CTRL, c);
  endtask

  // watchdog
  initial begin
    #(100000 * 5);
    n_fail++;
    end_of_test();
  end

  initial begin
    seed = 32'h09ecf72e;
    n_fail = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and the unmapped address
    for (int a = 0; a <= 8'h1c; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'(a == 8'h1c));
    end
    // writable bits read back, the rest read zero
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ra[i], 32'hffff_ffff);
      apb(1'b0, ra[i], 32'h0);
      check(rd, rm[i]);
    end
    apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
    // port data on pins with the timer outputs off
    for (int i = 0; i < 4; i++) begin
      d = $random(seed) & 15;
      apb(1'b1, `TMR8_OFF_PORT, 32'(d));
      repeat (3) @(posedge pclk);
      check(32'(pin_oe), 32'(d[1:0]));
      check(32'(pin_out), 32'(d[3:2]));
    end
    apb(1'b1, `TMR8_OFF_PORT, 32'h3);
    // toggle half period for prescale codes 1 to 7
    for (int k = 1; k < 8; k++) begin
      d = (k == 1) ? 0 : ($random(seed) & 3);
      setup(d, 0, {24'h0, `TMR8_COM_TOGGLE, 3'(k), `TMR8_WGM_CLEAR});
      edge_wait(0, hi);
      edge_wait(0, hi);
      edge_wait(0, hi);
      check(32'(hi), 32'(fac[k] * (d + 1)));
    end
    // compare written below the count: overflow first, then match
    apb(1'b1, `TMR8_OFF_CTRL, 32'h0);
    apb(1'b1, `TMR8_OFF_COUNT, 32'h90);
    apb(1'b1, `TMR8_OFF_CMPA, 32'h10);
    apb(1'b1, `TMR8_OFF_MASK, 32'h1);
    apb(1'b0, `TMR8_OFF_STAT, 32'h0);
    apb(1'b1, `TMR8_OFF_CTRL, {26'h0, `TMR8_CS_DIV1, `TMR8_WGM_CLEAR});
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge pclk);
    check(32'(irq), 32'h1);
    apb(1'b0, `TMR8_OFF_STAT, 32'h0);
    check(rd & 32'h3, 32'h1);
    repeat (40) @(posedge pclk);
    check(32'(irq), 32'h0);
    apb(1'b0, `TMR8_OFF_STAT, 32'h0);
    check(rd & 32'h3, 32'h2);
    apb(1'b1, `TMR8_OFF_MASK, 32'h2);
    repeat (40) @(posedge pclk);
    check(32'(irq), 32'h1);
    // fast pwm on channel b, both tops, both polarities
    for (int m = 0; m < 4; m++) begin
      top = m[0] ? 40 + ($random(seed) & 63) : 255;
      d = $random(seed) & 31;
      setup(top, d, {22'h0, m[1] ? `TMR8_COM_SET : `TMR8_COM_CLEAR, 2'h0,
                     `TMR8_CS_DIV1,
                     m[0] ? `TMR8_WGM_PWM_CMP : `TMR8_WGM_PWM_MAX});
      edge_wait(1, hi);
      edge_wait(1, hi);
      if (pin_out[1] !== 1'b1) edge_wait(1, hi);
      edge_wait(1, hi);
      edge_wait(1, lo);
      check(32'(hi), 32'(m[1] ? top - d : d + 1));
      check(32'(hi + lo), 32'(top + 1));
      apb(1'b0, `TMR8_OFF_STAT, 32'h0);
      repeat (300) @(posedge pclk);
      apb(1'b0, `TMR8_OFF_STAT, 32'h0);
      check(rd & 32'h7, 32'h7);
    end
    // channel a toggles at the compare top in fast pwm
    setup(top, 0, {22'h0, `TMR8_COM_OFF, `TMR8_COM_TOGGLE,
                   `TMR8_CS_DIV1, `TMR8_WGM_PWM_CMP});
    edge_wait(0, hi);
    edge_wait(0, hi);
    edge_wait(0, hi);
    check(32'(hi), 32'(top + 1));
    end_of_test();
  end
endmodule

`default_nettype wire
